// *** smis_core.sv ***
// sync timing supervision and channel input status objects
`timescale 1ns/1ps
`default_nettype none
module smis_core (
   input wire logic CLK_SYS,
   input wire logic RESET,
   // object access port
   input wire logic [15:0] OD_INDEX,
   input wire logic [7:0] OD_SUB,
   input wire logic OD_RD,
   input wire logic OD_WR,
   input wire logic [31:0] OD_WDATA,
   output logic [31:0] OD_RDATA,
   output logic OD_ACK,
   output logic OD_NACK,
   // timing event pins
   input wire logic FIRST_SYNC_PULSE,
   input wire logic SECOND_SYNC_PULSE,
   input wire logic SYNC_MANAGER_EVENT,
   // same-clock status from the node
   input wire logic RUN_STATE,
   input wire logic INPUT_SAMPLE,
   input wire logic INPUT_READY,
   // converter results per channel
   input wire logic [smis_pkg::NCH-1:0] CH_UPDATE,
   input wire logic [smis_pkg::NCH-1:0] CH_UNDER,
   input wire logic [smis_pkg::NCH-1:0] CH_OVER,
   input wire logic [smis_pkg::NCH-1:0] CH_ERROR,
   input wire logic [smis_pkg::NCH-1:0][15:0] CH_VALUE,
   input wire logic [smis_pkg::NCH-1:0][31:0] CH_SENSOR_RAW,
   input wire logic [smis_pkg::NCH-1:0][31:0] CH_LINE_RAW,
   input wire logic [smis_pkg::NCH-1:0][15:0] CH_SENSOR_RES,
   input wire logic [smis_pkg::NCH-1:0][15:0] CH_LINE_RES,
   output logic [smis_pkg::NCH-1:0] OPEN_CIRCUIT,
   output logic SYNC_ERROR
);
   import smis_pkg::*;

   // all block state in one record
   typedef struct packed {
      logic [15:0] mode;
      logic [15:0] cmd;
      logic [31:0] shift_ns;
      logic [31:0] calc_ns;
      logic [31:0] delay_ns;
      logic [15:0] missed;
      logic [15:0] overrun;
      logic [15:0] short_cnt;
      logic sync_err;
      logic [CNT_W-1:0] since_p1;   // cycles since cycle start (first pulse in clock mode, else manager event)
      logic [CNT_W-1:0] since_p2;   // cycles since second pulse
      logic [CNT_W-1:0] since_samp; // cycles since inputs sampled
      logic busy;                   // sampled, not yet handed over
      logic sm_seen;                // event seen this cycle
      logic [NCH-1:0] under;
      logic [NCH-1:0] over;
      logic [NCH-1:0] err;
      logic [NCH-1:0] toggle;
      logic [NCH-1:0] open_c;
      logic [NCH-1:0][15:0] value;
      logic [NCH-1:0][31:0] raw1;
      logic [NCH-1:0][31:0] raw2;
      logic [NCH-1:0][15:0] res1;
      logic [NCH-1:0][15:0] res2;
      logic [31:0] rdata;
      logic ack;
      logic nack;
   } smis_state_t;

   smis_state_t st_q;
   smis_state_t st_d;

   // cycle count to nanoseconds, cut to the entry width
   function automatic logic [31:0] to_ns(input logic [CNT_W-1:0] c);
      logic [31:0] w;
      // the timer reads one less than the edges between the two events
      w = 32'(c) + 32'h00000001;
      return 32'(w * 32'(CLK_PERIOD_NS));
   endfunction

   // keeps the larger of two times
   function automatic logic [31:0] max32(input logic [31:0] a, input logic [31:0] b);
      return (b > a) ? b : a;
   endfunction

   // counters stick at full scale instead of wrapping to zero
   function automatic logic [15:0] sat_inc(input logic [15:0] c);
      return (c == 16'hFFFF) ? c : 16'(c + 16'h0001);
   endfunction

   // object index of a channel given its base
   function automatic logic [15:0] ch_idx(input logic [15:0] base, input int n);
      return 16'(base + 16'(n) * IDX_CH_STEP);
   endfunction

   // pin events pass the three-stage sampler
   smis_pin_if ev ();
   assign ev.raw = {SYNC_MANAGER_EVENT, SECOND_SYNC_PULSE, FIRST_SYNC_PULSE};

   smis_pin_sampler u_samp (
      .clk(CLK_SYS),
      .rst(RESET),
      .pins(ev.samp)
   );

   logic p1_rise;
   logic p2_rise;
   logic sm_rise;
   logic dc_mode;
   logic cyc_start;
   logic wr_cmd;
   logic meas_start;
   assign p1_rise = ev.rise[0];
   assign p2_rise = ev.rise[1];
   assign sm_rise = ev.rise[2];
   // clock mode is either pulse-synchronous code
   assign dc_mode = (st_q.mode == MODE_PULSE1) || (st_q.mode == MODE_PULSE2);
   // a cycle begins at the first pulse in clock mode, else at the event
   assign cyc_start = dc_mode ? p1_rise : sm_rise;
   // a read in the same cycle wins, so the command write must not count then
   assign wr_cmd = OD_WR && !OD_RD && (OD_INDEX == IDX_SYNC) && (OD_SUB == SUB_CMD);
   assign meas_start = wr_cmd && (OD_WDATA[15:0] == CMD_START) && (st_q.cmd != CMD_START);

   // next-state logic
   always_comb begin
      st_d = st_q;
      st_d.ack = 1'b0;
      st_d.nack = 1'b0;

      // free-running cycle timers
      st_d.since_p1 = CNT_W'(st_q.since_p1 + 1'b1);
      st_d.since_p2 = CNT_W'(st_q.since_p2 + 1'b1);
      st_d.since_samp = CNT_W'(st_q.since_samp + 1'b1);
      if (p2_rise) begin
         st_d.since_p2 = '0;
      end

      if (cyc_start) begin
         if (dc_mode && RUN_STATE && !st_q.sm_seen) begin
            st_d.missed = sat_inc(st_q.missed);
         end
         if (RUN_STATE && st_q.busy) begin
            st_d.overrun = sat_inc(st_q.overrun);
         end
         st_d.sync_err = dc_mode && st_q.busy;
         st_d.since_p1 = '0;
         st_d.sm_seen = 1'b0;
      end
      // an event in the same cycle as the clear is kept
      if (sm_rise) begin
         st_d.sm_seen = 1'b1;
      end

      if (p2_rise && dc_mode && (32'(st_q.since_p1) < 32'(SHIFT_MIN_CYC))) begin
         st_d.short_cnt = sat_inc(st_q.short_cnt);
      end

      if (meas_start) begin
         st_d.shift_ns = '0;
         st_d.calc_ns = '0;
         st_d.delay_ns = '0;
      end

      // sampling of the inputs closes the shift and delay intervals
      if (INPUT_SAMPLE) begin
         st_d.busy = 1'b1;
         st_d.since_samp = '0;
         if (st_q.cmd == CMD_START && dc_mode && !meas_start) begin
            st_d.shift_ns = max32(st_q.shift_ns, to_ns(st_q.since_p1));
            st_d.delay_ns = max32(st_q.delay_ns, to_ns(st_q.since_p2));
         end
      end else if (INPUT_READY) begin
         st_d.busy = 1'b0;
         if (st_q.cmd == CMD_START && dc_mode && !meas_start) begin
            st_d.calc_ns = max32(st_q.calc_ns, to_ns(st_q.since_samp));
         end
      end

      // channel capture on each converter update
      for (int n = 0; n < NCH; n++) begin
         if (CH_UPDATE[n]) begin
            st_d.under[n] = CH_UNDER[n];
            st_d.over[n] = CH_OVER[n];
            st_d.err[n] = CH_ERROR[n];
            st_d.open_c[n] = CH_OVER[n] && CH_ERROR[n];
            st_d.toggle[n] = ~st_q.toggle[n];
            st_d.value[n] = CH_VALUE[n];
            st_d.raw1[n] = CH_SENSOR_RAW[n];
            st_d.raw2[n] = CH_LINE_RAW[n];
            st_d.res1[n] = CH_SENSOR_RES[n];
            st_d.res2[n] = CH_LINE_RES[n];
         end
      end

      // object reads answer one cycle after the strobe
      if (OD_RD) begin
         st_d.ack = 1'b1;
         st_d.rdata = '0;
         if (OD_INDEX == IDX_SYNC) begin
            case (OD_SUB)
               SUB_COUNT: st_d.rdata = 32'(SYNC_ENTRIES);
               SUB_MODE: st_d.rdata = 32'(st_q.mode);
               SUB_SHIFT: st_d.rdata = st_q.shift_ns;
               SUB_MODES: st_d.rdata = 32'(MODES_SUPPORTED);
               SUB_MINCYC: st_d.rdata = MIN_CYCLE_NS;
               SUB_CALC: st_d.rdata = st_q.calc_ns;
               SUB_CMD: st_d.rdata = 32'(st_q.cmd);
               SUB_DELAY: st_d.rdata = st_q.delay_ns;
               SUB_MISSED: st_d.rdata = 32'(st_q.missed);
               SUB_OVERRUN: st_d.rdata = 32'(st_q.overrun);
               SUB_SHORT: st_d.rdata = 32'(st_q.short_cnt);
               SUB_SYNCERR: st_d.rdata = 32'(st_q.sync_err);
               default: begin
                  st_d.ack = 1'b0;
                  st_d.nack = 1'b1;
               end
            endcase
         end else if (OD_INDEX == IDX_SFRAME || OD_INDEX == IDX_MFRAME) begin
            // safety frame elements are reserved and read zero
            if (OD_SUB == SUB_COUNT) begin
               st_d.rdata = (OD_INDEX == IDX_SFRAME) ? 32'(SFRAME_ENTRIES)
                                                    : 32'(MFRAME_ENTRIES);
            end else if (OD_SUB > ((OD_INDEX == IDX_SFRAME) ? SFRAME_ENTRIES
                                                            : MFRAME_ENTRIES)) begin
               st_d.ack = 1'b0;
               st_d.nack = 1'b1;
            end
         end else begin
            st_d.ack = 1'b0;
            st_d.nack = 1'b1;
            for (int n = 0; n < NCH; n++) begin
               if (OD_INDEX == ch_idx(IDX_CH_BASE, n)) begin
                  st_d.ack = 1'b1;
                  st_d.nack = 1'b0;
                  case (OD_SUB)
                     SUB_COUNT: st_d.rdata = 32'(CH_ENTRIES);
                     SUB_UNDER: st_d.rdata = 32'(st_q.under[n]);
                     SUB_OVER: st_d.rdata = 32'(st_q.over[n]);
                     SUB_ERR: st_d.rdata = 32'(st_q.err[n]);
                     SUB_VALID: st_d.rdata = 32'(st_q.err[n]);
                     SUB_TOGGLE: st_d.rdata = 32'(st_q.toggle[n]);
                     SUB_VALUE: st_d.rdata = 32'(signed'(st_q.value[n]));
                     default: begin
                        st_d.ack = 1'b0;
                        st_d.nack = 1'b1;
                     end
                  endcase
               end else if (OD_INDEX == ch_idx(IDX_INT_BASE, n)) begin
                  st_d.ack = 1'b1;
                  st_d.nack = 1'b0;
                  case (OD_SUB)
                     SUB_COUNT: st_d.rdata = 32'(INT_ENTRIES);
                     SUB_RAW1: st_d.rdata = st_q.raw1[n];
                     SUB_RES1: st_d.rdata = 32'(st_q.res1[n]);
                     SUB_RAW2: st_d.rdata = st_q.raw2[n];
                     SUB_RES2: st_d.rdata = 32'(st_q.res2[n]);
                     default: begin
                        st_d.ack = 1'b0;
                        st_d.nack = 1'b1;
                     end
                  endcase
               end
            end
         end
      end else if (OD_WR) begin
         // only mode and command are writable; all else is refused
         st_d.nack = 1'b1;
         if (OD_INDEX == IDX_SYNC && OD_SUB == SUB_MODE) begin
            st_d.mode = OD_WDATA[15:0];
            st_d.nack = 1'b0;
            st_d.ack = 1'b1;
         end else if (wr_cmd) begin
            st_d.cmd = OD_WDATA[15:0];
            st_d.nack = 1'b0;
            st_d.ack = 1'b1;
         end
      end
   end

   // registers take constants only under reset
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         st_q <= '0;
         st_q.mode <= RST_MODE;
         st_q.cmd <= RST_CMD;
      end else begin
         st_q <= st_d;
      end
   end

   // outputs come straight from the state record
   assign OD_RDATA = st_q.rdata;
   assign OD_ACK = st_q.ack;
   assign OD_NACK = st_q.nack;
   assign OPEN_CIRCUIT = st_q.open_c;
   assign SYNC_ERROR = st_q.sync_err;

   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (RESET);

   toggle_flip_a : assert property (CH_UPDATE[0] |=> st_q.toggle[0] != $past(st_q.toggle[0]))
      else $error("toggle did not invert on update");
   open_sensor_a : assert property (CH_UPDATE[1]
      |=> OPEN_CIRCUIT[1] == ($past(CH_OVER[1]) && $past(CH_ERROR[1])))
      else $error("open circuit not over and error");
   missed_count_a : assert property ((cyc_start && dc_mode && RUN_STATE && !st_q.sm_seen
      && st_q.missed != 16'hFFFF) |=> st_q.missed == 16'($past(st_q.missed) + 16'h0001))
      else $error("missed event not counted");
   overrun_count_a : assert property ((cyc_start && RUN_STATE && st_q.busy
      && st_q.overrun != 16'hFFFF) |=> st_q.overrun == 16'($past(st_q.overrun) + 16'h0001))
      else $error("overrun not counted");
   overrun_idle_a : assert property (!RUN_STATE |=> st_q.overrun == $past(st_q.overrun))
      else $error("overrun counted outside run state");
   short_gap_a : assert property ((p2_rise && dc_mode
      && st_q.since_p1 < CNT_W'(SHIFT_MIN_CYC) && st_q.short_cnt != 16'hFFFF)
      |=> st_q.short_cnt == 16'($past(st_q.short_cnt) + 16'h0001))
      else $error("short gap not counted");
   meas_clear_a : assert property (meas_start |=> st_q.shift_ns == 32'h0
      && st_q.calc_ns == 32'h0 && st_q.delay_ns == 32'h0)
      else $error("maxima not cleared on start");
   sync_err_a : assert property (cyc_start |=> SYNC_ERROR == ($past(dc_mode) && $past(st_q.busy)))
      else $error("sync error flag wrong");
   modes_read_a : assert property ((OD_RD && OD_INDEX == IDX_SYNC && OD_SUB == SUB_MODES)
      |=> OD_ACK && OD_RDATA == 32'h00004027)
      else $error("supported modes word wrong");
   cmd_write_a : assert property (wr_cmd |=> st_q.cmd == $past(OD_WDATA[15:0]) && OD_ACK)
      else $error("command not taken");

   meas_cov : cover property (meas_start ##[1:200] INPUT_READY);
   missed_cov : cover property (cyc_start && dc_mode && RUN_STATE && !st_q.sm_seen);
   update_cov : cover property (CH_UPDATE[0] ##1 CH_UPDATE[0]);
endmodule
`default_nettype wire

// *** smis_master_model.sv ***
// fieldbus master model issuing object reads and writes
`timescale 1ns/1ps
`default_nettype none
module smis_master_model (
   input wire logic clk,
   output logic [15:0] od_index,
   output logic [7:0] od_sub,
   output logic od_rd,
   output logic od_wr,
   output logic [31:0] od_wdata,
   input wire logic [31:0] od_rdata,
   input wire logic od_ack,
   input wire logic od_nack
);
   // bus idle from time zero
   initial begin
      {od_rd, od_wr, od_index, od_sub, od_wdata} = '0;
   end
   // one access: strobe for one cycle, answer one cycle after it is taken
   task automatic access(input logic wr, input logic [15:0] i, input logic [7:0] s,
                         input logic [31:0] d, output logic [31:0] r, output logic nk);
      @(posedge clk);
      od_index <= i;
      od_sub <= s;
      od_wdata <= d;
      od_rd <= !wr;
      od_wr <= wr;
      @(posedge clk);
      od_rd <= 1'b0;
      od_wr <= 1'b0;
      // released lines carry the inverse so stale values cannot pass
      od_index <= ~i;
      od_sub <= ~s;
      od_wdata <= ~d;
      @(posedge clk);
      r = od_rdata;
      // neither or both answers poison the refusal flag
      nk = (od_ack !== od_nack) ? od_nack : 1'bx;
   endtask
endmodule
`default_nettype wire

// *** smis_pin_if.sv ***
// carrier between the pin sampler and the monitor core
`timescale 1ns/1ps
`default_nettype none
interface smis_pin_if;
   logic [2:0] raw;  // asynchronous event pins
   logic [2:0] rise; // one-cycle pulse per filtered rising edge
   modport samp(input raw, output rise);
   modport user(output raw, input rise);
endinterface
`default_nettype wire

// *** smis_pin_sampler.sv ***
// three-stage pin sampler with agreement filter and edge pulse
`timescale 1ns/1ps
`default_nettype none
module smis_pin_sampler (
   input wire logic clk,
   input wire logic rst,
   smis_pin_if.samp pins
);
   import smis_pkg::*;

   // sampler state
   typedef struct packed {
      logic [2:0] s1;     // first stage, read by s2 only
      logic [2:0] s2;
      logic [2:0] s3;
      logic [2:0] stable; // accepted level
      logic [2:0] rise;
   } smis_samp_t;

   smis_samp_t st_q;
   smis_samp_t st_d;

   // a level counts only once stages two and three agree
   always_comb begin
      st_d = st_q;
      st_d.s1 = pins.raw;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      for (int i = 0; i < 3; i++) begin
         if (st_q.s2[i] == st_q.s3[i]) begin
            st_d.stable[i] = st_q.s3[i];
         end
      end
      st_d.rise = st_d.stable & ~st_q.stable;
   end

   // constants only under reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign pins.rise = st_q.rise;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sample_pulse_a : assert property (st_q.rise != 3'h0 |=> (st_q.rise & $past(st_q.rise)) == 3'h0)
      else $error("edge pulse longer than one cycle");
endmodule
`default_nettype wire

// *** smis_pkg.sv ***
// constants for the sync monitor and input status object set
package smis_pkg;
   localparam int NCH = 4;
   localparam int CLK_PERIOD_NS = 8;
   // object indices
   localparam logic [15:0] IDX_SYNC = 16'h1C33;
   localparam logic [15:0] IDX_CH_BASE = 16'h6000;
   localparam logic [15:0] IDX_INT_BASE = 16'h800E;
   localparam logic [15:0] IDX_CH_STEP = 16'h0010;
   localparam logic [15:0] IDX_SFRAME = 16'h6040;
   localparam logic [15:0] IDX_MFRAME = 16'h7040;
   // sync object subindices
   localparam logic [7:0] SUB_COUNT = 8'h00;
   localparam logic [7:0] SUB_MODE = 8'h01;
   localparam logic [7:0] SUB_SHIFT = 8'h03;
   localparam logic [7:0] SUB_MODES = 8'h04;
   localparam logic [7:0] SUB_MINCYC = 8'h05;
   localparam logic [7:0] SUB_CALC = 8'h06;
   localparam logic [7:0] SUB_CMD = 8'h08;
   localparam logic [7:0] SUB_DELAY = 8'h09;
   localparam logic [7:0] SUB_MISSED = 8'h0B;
   localparam logic [7:0] SUB_OVERRUN = 8'h0C;
   localparam logic [7:0] SUB_SHORT = 8'h0D;
   localparam logic [7:0] SUB_SYNCERR = 8'h20;
   // channel input subindices
   localparam logic [7:0] SUB_UNDER = 8'h01;
   localparam logic [7:0] SUB_OVER = 8'h02;
   localparam logic [7:0] SUB_ERR = 8'h07;
   localparam logic [7:0] SUB_VALID = 8'h0F;
   localparam logic [7:0] SUB_TOGGLE = 8'h10;
   localparam logic [7:0] SUB_VALUE = 8'h11;
   // internal data subindices
   localparam logic [7:0] SUB_RAW1 = 8'h01;
   localparam logic [7:0] SUB_RES1 = 8'h02;
   localparam logic [7:0] SUB_RAW2 = 8'h03;
   localparam logic [7:0] SUB_RES2 = 8'h04;
   // fixed entry counts and values
   localparam logic [7:0] SYNC_ENTRIES = 8'h20;
   localparam logic [7:0] CH_ENTRIES = 8'h11;
   localparam logic [7:0] SFRAME_ENTRIES = 8'h06;
   localparam logic [7:0] MFRAME_ENTRIES = 8'h03;
   localparam logic [7:0] INT_ENTRIES = 8'h04;
   // free run, event, clock mode 01, shift by second pulse, dynamic times
   localparam logic [15:0] MODES_SUPPORTED = 16'h4027;
   localparam logic [15:0] RST_MODE = 16'h0000;
   localparam logic [15:0] RST_CMD = 16'h0000;
   localparam logic [15:0] CMD_START = 16'h0001;
   // sync mode codes
   localparam logic [15:0] MODE_FREE = 16'h0000;
   localparam logic [15:0] MODE_SM_IN = 16'h0001;
   localparam logic [15:0] MODE_PULSE1 = 16'h0002;
   localparam logic [15:0] MODE_PULSE2 = 16'h0003;
   localparam logic [15:0] MODE_SM_OUT = 16'h0022;
   // shortest legal gap between first and second pulse
   localparam int SHIFT_MIN_NS = 1000;
   localparam int SHIFT_MIN_CYC = (SHIFT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [31:0] MIN_CYCLE_NS = 32'h0000C350;
   localparam int CNT_W = 29;
endpackage

// *** sync_monitor_input_status_tb.sv ***
// self-checking bench for the sync monitor and input status objects
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module sync_monitor_input_status_tb;
   import smis_pkg::*;
   logic clk_sys, reset, ack, nack, run, sync_err, nk, rde, wre;
   logic [15:0] idx, b, ib;
   logic [7:0] sub;
   logic [1:0] c;
   logic [31:0] wd, rdata, rd, seed, m0, o0, s0;
   logic [2:0] pin; // first pulse, second pulse, manager event
   logic [1:0] io; // sample, ready
   logic [NCH-1:0] upd, under, over, err, open_c, tog;
   logic [NCH-1:0][15:0] val, sres, lres;
   logic [NCH-1:0][31:0] sraw, lraw;
   logic [7:0] zs [9] = '{SUB_MODE, SUB_SHIFT, SUB_CALC, SUB_CMD, SUB_DELAY,
                          SUB_MISSED, SUB_OVERRUN, SUB_SHORT, SUB_SYNCERR};
   logic [15:0] mc [5] = '{MODE_FREE, MODE_SM_IN, MODE_PULSE1, MODE_PULSE2, MODE_SM_OUT};
   int errors, check_count;
   smis_master_model m_u (.clk(clk_sys), .od_index(idx), .od_sub(sub), .od_rd(rde),
      .od_wr(wre), .od_wdata(wd), .od_rdata(rdata), .od_ack(ack), .od_nack(nack));
   smis_core dut_u (.CLK_SYS(clk_sys), .RESET(reset), .OD_INDEX(idx), .OD_SUB(sub),
      .OD_RD(rde), .OD_WR(wre), .OD_WDATA(wd), .OD_RDATA(rdata), .OD_ACK(ack),
      .OD_NACK(nack), .FIRST_SYNC_PULSE(pin[0]), .SECOND_SYNC_PULSE(pin[1]),
      .SYNC_MANAGER_EVENT(pin[2]), .RUN_STATE(run), .INPUT_SAMPLE(io[0]),
      .INPUT_READY(io[1]), .CH_UPDATE(upd), .CH_UNDER(under), .CH_OVER(over),
      .CH_ERROR(err), .CH_VALUE(val), .CH_SENSOR_RAW(sraw), .CH_LINE_RAW(lraw),
      .CH_SENSOR_RES(sres), .CH_LINE_RES(lres), .OPEN_CIRCUIT(open_c),
      .SYNC_ERROR(sync_err));
   // xorshift source, fixed start keeps runs repeatable
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   // expected word of a signed 16-bit entry
   function automatic logic [31:0] sx(input logic [15:0] v);
      return {{16{v[15]}}, v};
   endfunction
   task automatic rdc(input logic [15:0] i, input logic [7:0] s, input logic [31:0] e);
      m_u.access(1'b0, i, s, 32'h0, rd, nk);
      `CHK(nk, 1'b0)
      `CHK(rd, e)
   endtask
   task automatic rdv(input logic [7:0] s, output logic [31:0] v);
      m_u.access(1'b0, IDX_SYNC, s, 32'h0, v, nk);
   endtask
   task automatic wrc(input logic [7:0] s, input logic [31:0] d, input logic en);
      m_u.access(1'b1, IDX_SYNC, s, d, rd, nk);
      `CHK(nk, en)
   endtask
   // pin held long enough for the sampler, then time for the count to land
   task automatic pulse(input int w);
      @(posedge clk_sys);
      pin[w] <= 1'b1;
      repeat (6) @(posedge clk_sys);
      pin[w] <= 1'b0;
      repeat (8) @(posedge clk_sys);
   endtask
   task automatic strobe(input int w);
      @(posedge clk_sys);
      io[w] <= 1'b1;
      @(posedge clk_sys);
      io[w] <= 1'b0;
   endtask
   // one clock-mode cycle: optional manager event and hand-over, then first pulse
   task automatic tick(input logic sm, input logic done);
      if (sm) pulse(2);
      strobe(0);
      if (done) strobe(1);
      pulse(0);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // whole run is about a thousand cycles; this bound means a hang
   initial begin
      #400000;
      errors++;
      wrap_up();
   end
   initial begin
      seed = 32'd54;
      reset = 1'b1;
      {run, pin, io, upd, under, over, err, tog} = '0;
      {val, sres, lres, sraw, lraw} = '0;
      repeat (12) @(posedge clk_sys);
      reset <= 1'b0;
      `CHK({open_c, sync_err}, 5'h00)
      rdc(IDX_SYNC, SUB_COUNT, 32'h20);
      rdc(IDX_SYNC, SUB_MODES, {16'h0, MODES_SUPPORTED});
      `CHK(rd[3:0], 4'h7)
      `CHK(rd[5:4], 2'b10)
      `CHK(rd[14], 1'b1)
      rdc(IDX_SYNC, SUB_MINCYC, MIN_CYCLE_NS);
      foreach (zs[k]) rdc(IDX_SYNC, zs[k], 32'h0);
      rdc(IDX_CH_BASE, SUB_COUNT, 32'h11);
      rdc(IDX_SFRAME, SUB_COUNT, 32'h6);
      rdc(IDX_SFRAME, 8'h06, 32'h0);
      rdc(IDX_MFRAME, SUB_COUNT, 32'h3);
      rdc(IDX_INT_BASE + 16'h0030, SUB_COUNT, 32'h4);
      // read-only and unmapped places are refused
      wrc(SUB_MODES, 32'h0, 1'b1);
      wrc(SUB_MINCYC, 32'h1, 1'b1);
      rdc(IDX_SYNC, SUB_MINCYC, MIN_CYCLE_NS);
      m_u.access(1'b0, 16'h1234, 8'h00, 32'h0, rd, nk);
      `CHK({nk, rd}, 33'h1_0000_0000)
      foreach (mc[k]) begin
         wrc(SUB_MODE, {16'h0, mc[k]}, 1'b0);
         rdc(IDX_SYNC, SUB_MODE, {16'h0, mc[k]});
      end
      $display("test registers done");
      // random channel updates, first ones forced to an open sensor
      for (int i = 0; i < 12; i++) begin
         seed = xs(seed);
         c = seed[1:0];
         b = IDX_CH_BASE + {10'h0, c, 4'h0};
         ib = IDX_INT_BASE + {10'h0, c, 4'h0};
         @(posedge clk_sys);
         upd[c] <= 1'b1;
         {under[c], over[c], err[c]} <= (i < 4) ? 3'b011 : seed[4:2];
         val[c] <= (i == 0) ? 16'h8000 : seed[31:16];
         sraw[c] <= {seed[15:0], seed[31:16]};
         lraw[c] <= ~seed;
         sres[c] <= seed[27:12];
         lres[c] <= seed[19:4];
         @(posedge clk_sys);
         upd[c] <= 1'b0;
         tog[c] = ~tog[c];
         repeat (2) @(posedge clk_sys);
         `CHK(open_c[c], over[c] & err[c])
         rdc(b, SUB_UNDER, {31'h0, under[c]});
         rdc(b, SUB_OVER, {31'h0, over[c]});
         rdc(b, SUB_ERR, {31'h0, err[c]});
         rdc(b, SUB_VALID, {31'h0, err[c]});
         rdc(b, SUB_TOGGLE, {31'h0, tog[c]});
         rdc(b, SUB_VALUE, sx(val[c]));
         rdc(ib, SUB_RAW1, sraw[c]);
         rdc(ib, SUB_RES1, {16'h0, sres[c]});
         rdc(ib, SUB_RAW2, lraw[c]);
         rdc(ib, SUB_RES2, {16'h0, lres[c]});
      end
      $display("test channels done");
      wrc(SUB_MODE, 32'h2, 1'b0);
      run <= 1'b1;
      tick(1'b1, 1'b1);
      tick(1'b1, 1'b1);
      rdv(SUB_MISSED, m0);
      rdv(SUB_OVERRUN, o0);
      tick(1'b1, 1'b1);
      rdc(IDX_SYNC, SUB_MISSED, m0);
      rdc(IDX_SYNC, SUB_OVERRUN, o0);
      `CHK(sync_err, 1'b0)
      tick(1'b0, 1'b0);
      rdc(IDX_SYNC, SUB_MISSED, m0 + 1);
      rdc(IDX_SYNC, SUB_OVERRUN, o0 + 1);
      rdc(IDX_SYNC, SUB_SYNCERR, 32'h1);
      `CHK(sync_err, 1'b1)
      tick(1'b1, 1'b1);
      `CHK(sync_err, 1'b0)
      // free run: manager event starts the cycle, no clock-mode counting
      wrc(SUB_MODE, 32'h0, 1'b0);
      strobe(0);
      pulse(2);
      rdc(IDX_SYNC, SUB_MISSED, m0 + 1);
      rdc(IDX_SYNC, SUB_OVERRUN, o0 + 2);
      run <= 1'b0;
      strobe(0);
      pulse(2);
      rdc(IDX_SYNC, SUB_OVERRUN, o0 + 2);
      $display("test counters done");
      wrc(SUB_MODE, 32'h2, 1'b0);
      run <= 1'b1;
      rdv(SUB_SHORT, s0);
      pulse(0);
      pulse(1);
      rdc(IDX_SYNC, SUB_SHORT, s0 + 1);
      pulse(0);
      repeat (150) @(posedge clk_sys);
      pulse(1);
      rdc(IDX_SYNC, SUB_SHORT, s0 + 1);
      // measurement: sample to ready spans seven cycles
      wrc(SUB_CMD, 32'h1, 1'b0);
      pulse(0);
      pulse(1);
      strobe(0);
      repeat (5) @(posedge clk_sys);
      strobe(1);
      rdc(IDX_SYNC, SUB_CALC, 32'd56);
      rdv(SUB_SHIFT, m0);
      `CHK(m0 != 32'h0, 1'b1)
      rdv(SUB_DELAY, m0);
      `CHK(m0 != 32'h0, 1'b1)
      wrc(SUB_CMD, 32'h0, 1'b0);
      rdc(IDX_SYNC, SUB_CMD, 32'h0);
      wrc(SUB_CMD, 32'h1, 1'b0);
      rdc(IDX_SYNC, SUB_CALC, 32'h0);
      rdc(IDX_SYNC, SUB_SHIFT, 32'h0);
      rdc(IDX_SYNC, SUB_DELAY, 32'h0);
      $display("test timing done");
      wrap_up();
   end
endmodule
`default_nettype wire
